/* File: include/cable_vsb_pkg.sv */
// Framing, interleaver and level constants shared by the cable symbol path
package cable_vsb_pkg;

  // Segment and field framing, identical to the terrestrial mode
  localparam logic [9:0]  SEG_SYMS       = 10'd832;  // Symbols per segment
  localparam logic [9:0]  SYNC_SYMS      = 10'd4;    // Segment sync symbols
  localparam logic [9:0]  DATA_SYMS      = 10'd828;  // Data symbols/segment
  localparam logic [8:0]  FIELD_SEGS     = 9'd313;   // Segments per field
  localparam logic [8:0]  CW_BYTES       = 9'd207;   // Codeword length
  localparam logic [8:0]  RS_PAYLOAD     = 9'd187;   // Payload bytes/word
  localparam logic [8:0]  RS_PARITY      = 9'd20;    // Parity bytes/word
  localparam logic [8:0]  TS_BYTES       = 9'd188;   // Transport bytes/packet

  // Symbol alphabet: 16 levels, 4 bits each, scaled integer amplitudes
  localparam int          SYM_W          = 9;
  localparam logic [4:0]  LEVELS         = 5'd16;
  localparam logic signed [8:0] LEVEL_STEP = 9'sd8;  // Half level spacing
  localparam logic signed [8:0] PILOT_OFS  = 9'sd10; // Pilot dc offset
  localparam logic signed [8:0] SYNC_AMP   = 9'sd40; // Two-level amplitude

  // Level count code sent two-level in the field sync segment
  localparam logic [9:0]  CODE_POS       = 10'd104;  // First code symbol
  localparam logic [3:0]  LEVEL_CODE_16  = 4'hF;     // Code for 16 levels
  localparam logic [8:0]  FS_PN_SEED     = 9'h1FF;   // Field sync pattern

  // Convolutional byte interleaver over 26 data segments
  localparam logic [5:0]  INTLV_SEGS     = 6'd26;
  localparam logic [5:0]  INTLV_BRANCH   = 6'd52;    // Branch count
  localparam logic [13:0] INTLV_UNIT     = 14'd4;    // Bytes per branch step
  localparam logic [13:0] INTLV_DEPTH    = 14'd10609; // Ring size in bytes
  localparam int          PTR_W          = 14;

  // Receive de-randomizer generator
  localparam logic [15:0] PRS_SEED       = 16'hF180;
  localparam logic [15:0] PRS_TAPS       = 16'hD008;

  // Data FIFO ahead of the interleaver
  localparam int          FIFO_W         = 8;
  localparam int          FIFO_DEPTH     = 16;

endpackage

/* File: rtl/cable_vsb_symbol_path.sv */
// Cable mode 16-level symbol path: interleave, map, slice, de-interleave
`timescale 1ns/1ps

module byte_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Fill side
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  // Drain side
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0]   wp;    // Write pointer with wrap bit
    logic [AW:0]   rp;    // Read pointer with wrap bit
    logic          room;  // Registered not-full flag
    logic          empty; // Registered empty flag
  } fifo_st_t;

  fifo_st_t     st_q;        // Pointer state
  fifo_st_t     st_d;        // Next pointer state
  logic [W-1:0] mem [DEPTH]; // Storage words
  logic         push;        // Word accepted
  logic         pop;         // Word drained

  assign push        = in_valid_i & st_q.room;
  assign pop         = out_ready_i & ~st_q.empty;
  assign in_ready_o  = st_q.room;
  assign out_valid_o = ~st_q.empty;
  assign out_data_o  = mem[st_q.rp[AW-1:0]];

  // Pointer update; flags registered so ready and valid come from flops
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.wp = st_q.wp + 1'b1;
    end
    if (pop) begin
      st_d.rp = st_q.rp + 1'b1;
    end
    st_d.empty = (st_d.wp == st_d.rp);
    st_d.room  = (st_d.wp[AW-1:0] != st_d.rp[AW-1:0]) ||
                 (st_d.wp[AW] == st_d.rp[AW]);
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '{wp: '0, rp: '0, room: 1'b1, empty: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end

  // Storage has no reset; contents are only read once written
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[st_q.wp[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// Summary of operation
// RULE_01: Symbol, segment, field timing as terrestrial mode
// RULE_02: Map each 4-bit group to 16 levels
// RULE_03: Slice 16 levels to 4 bits, no trellis
// RULE_04: 828 data symbols carry two 207-byte codewords
// RULE_05: 26-segment byte interleaver, exact inverse on receive
// RULE_06: One field sync per 313 segments, 312 payload
// RULE_07: Field sync carries two-level level count code
// RULE_08: Keep pilot offset, segment sync, field sync
// RULE_09: De-interleaver aligns to field sync
// RULE_10: De-randomizer generator locked to field sync
// RULE_11: Segment sync first, bypasses mapper, counter restarts
module cable_vsb_symbol_path
  import cable_vsb_pkg::*;
(
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             sys_rst_i,
  // Transmit coded byte stream
  input  wire logic [7:0]       tx_byte_i,
  input  wire logic             tx_valid_i,
  output logic                  tx_ready_o,
  // Transmit symbol stream to modulator
  input  wire logic             tx_sym_req_i,
  output logic [SYM_W-1:0]      tx_sym_o,
  output logic                  tx_sym_valid_o,
  output logic                  tx_seg_start_o,
  output logic                  tx_field_start_o,
  output logic                  tx_underflow_o,
  // Receive symbol stream from demodulator
  input  wire logic [SYM_W-1:0] rx_sym_i,
  input  wire logic             rx_sym_valid_i,
  input  wire logic             rx_field_start_i,
  // Receive byte stream to error correction
  output logic [7:0]            rx_byte_o,
  output logic                  rx_byte_valid_o,
  output logic [3:0]            rx_level_code_o,
  output logic                  rx_levels_ok_o,
  output logic                  rx_locked_o,
  // Corrected bytes in, de-randomized bytes out
  input  wire logic [7:0]       corr_byte_i,
  input  wire logic             corr_valid_i,
  output logic [7:0]            derand_byte_o,
  output logic                  derand_valid_o
);

  // Distance back along a ring, wrapping at the interleaver depth
  function automatic logic [PTR_W-1:0] ring_back(
    input logic [PTR_W-1:0] p, input logic [PTR_W-1:0] d);
    logic [PTR_W:0] s;
    s = {1'b0, p} + {1'b0, INTLV_DEPTH} - {1'b0, d};
    if (s >= {1'b0, INTLV_DEPTH}) begin
      s = s - {1'b0, INTLV_DEPTH};
    end
    return s[PTR_W-1:0];
  endfunction

  // Byte delay of a branch: branch times branch count times unit
  function automatic logic [PTR_W-1:0] branch_delay(input logic [5:0] b);
    logic [PTR_W-1:0] w;
    w = {8'h00, b} * {8'h00, INTLV_BRANCH};
    return PTR_W'(w * INTLV_UNIT);
  endfunction

  // Pointer step with wrap at the ring size
  function automatic logic [PTR_W-1:0] ring_next(input logic [PTR_W-1:0] p);
    return (p == INTLV_DEPTH - 14'd1) ? '0 : p + 14'd1;
  endfunction

  // Transmit state
  typedef struct packed {
    logic [9:0]       pos;     // Symbol position within segment
    logic [8:0]       seg;     // Segment within field, 0 is field sync
    logic             need;    // Next data symbol starts a new byte
    logic [3:0]       lo;      // Held low nibble
    logic [5:0]       br;      // Interleaver branch
    logic [PTR_W-1:0] wp;      // Ring write pointer
    logic [8:0]       pn;      // Field sync pattern generator
    logic [SYM_W-1:0] sym;     // Output symbol
    logic             sym_v;   // Output symbol strobe
    logic             seg_st;  // First symbol of segment
    logic             fld_st;  // First symbol of field
    logic             unf;     // No byte ready when needed
  } tx_st_t;

  // Receive state
  typedef struct packed {
    logic             lock;    // Field sync has been seen
    logic [9:0]       pos;     // Symbol position within segment
    logic [8:0]       seg;     // Segment within field
    logic             hi;      // Next slice is a high nibble
    logic [3:0]       nib;     // Held high nibble
    logic [5:0]       br;      // De-interleaver branch
    logic [PTR_W-1:0] wp;      // Ring write pointer
    logic [3:0]       code;    // Code being gathered
    logic [3:0]       code_q;  // Level code in force
    logic             lvl16;   // Code selects 16 levels
    logic [7:0]       byt;     // Output byte
    logic             byt_v;   // Output byte strobe
    logic [15:0]      prs;     // De-randomizer generator
    logic [7:0]       der;     // De-randomized byte
    logic             der_v;   // De-randomized strobe
  } rx_st_t;

  tx_st_t      tx_q;                     // Transmit register
  tx_st_t      tx_d;                     // Transmit next value
  rx_st_t      rx_q;                     // Receive register
  rx_st_t      rx_d;                     // Receive next value
  logic [7:0]  tx_mem [INTLV_DEPTH];     // Interleaver ring
  logic [7:0]  rx_mem [INTLV_DEPTH];     // De-interleaver ring
  logic [7:0]  fifo_data;                // Byte at FIFO head
  logic        fifo_valid;               // FIFO holds a byte
  logic        fifo_pop;                 // Interleaver takes a byte
  logic [7:0]  tx_in;                    // Byte entering interleaver
  logic        tx_wr;                    // Interleaver ring write
  logic [7:0]  rx_in;                    // Byte entering de-interleaver
  logic        rx_wr;                    // De-interleaver ring write
  logic [7:0]  tx_old;                   // Delayed byte from ring
  logic [7:0]  rx_old;                   // Delayed byte from ring
  logic [3:0]  slice;                    // Sliced nibble

  // Source is stalled by the FIFO when the symbol side falls behind
  byte_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i       (sys_clk_i),
    .rst_i       (sys_rst_i),
    .in_data_i   (tx_byte_i),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop)
  );

  assign tx_old = tx_mem[ring_back(tx_q.wp, branch_delay(tx_q.br))];
  assign rx_old = rx_mem[ring_back(rx_q.wp,
                         branch_delay(INTLV_BRANCH - 6'd1 - rx_q.br))];

  // Sixteen-level slicer: remove pilot, round to nearest level
  always_comb begin
    logic signed [10:0] x;
    x = 11'(signed'(rx_sym_i)) - 11'(PILOT_OFS) +
        11'(LEVEL_STEP) * 11'sd16;                      // RULE_03
    if (x < 0) begin
      slice = 4'h0;
    end else if (x[10:4] > 7'd15) begin
      slice = 4'hF;
    end else begin
      slice = x[7:4];
    end
  end

  // Transmit framing, interleaving and mapping
  always_comb begin
    logic [7:0] b;
    tx_d        = tx_q;
    tx_d.sym_v  = 1'b0;
    tx_d.seg_st = 1'b0;
    tx_d.fld_st = 1'b0;
    tx_d.unf    = 1'b0;
    fifo_pop    = 1'b0;
    tx_wr       = 1'b0;
    tx_in       = 8'h00;
    b           = 8'h00;
    if (tx_sym_req_i) begin
      tx_d.sym_v  = 1'b1;
      tx_d.seg_st = (tx_q.pos == 10'd0);
      tx_d.fld_st = (tx_q.pos == 10'd0) && (tx_q.seg == 9'd0);
      if (tx_q.pos < SYNC_SYMS) begin
        // Segment sync pattern +,-,-,+ bypasses the mapper
        tx_d.sym = (tx_q.pos == 10'd0 || tx_q.pos == 10'd3) ?
                   SYNC_AMP : -SYNC_AMP;                // RULE_11 RULE_08
        tx_d.need = 1'b1;
      end else if (tx_q.seg == 9'd0) begin
        // Field sync segment, all two-level, level code inside
        if (tx_q.pos >= CODE_POS && tx_q.pos < CODE_POS + 10'd4) begin
          tx_d.sym = LEVEL_CODE_16[2'(CODE_POS + 10'd3 - tx_q.pos)] ?
                     SYNC_AMP : -SYNC_AMP;              // RULE_07
        end else begin
          tx_d.sym = tx_q.pn[0] ? SYNC_AMP : -SYNC_AMP; // RULE_08
          tx_d.pn  = {tx_q.pn[4] ^ tx_q.pn[0], tx_q.pn[8:1]};
        end
        tx_d.br = 6'd0;                                 // RULE_09
      end else if (tx_q.need) begin
        // New byte: take from FIFO, send through its branch
        fifo_pop  = 1'b1;
        tx_d.unf  = ~fifo_valid;
        tx_in     = fifo_valid ? fifo_data : 8'h00;
        tx_wr     = 1'b1;
        b = (tx_q.br == 6'd0) ? tx_in : tx_old;         // RULE_05
        tx_d.wp = ring_next(tx_q.wp);
        tx_d.br = (tx_q.br == INTLV_BRANCH - 6'd1) ? 6'd0 : tx_q.br + 6'd1;
        tx_d.sym = SYM_W'(9'({5'd0, b[7:4]}) * LEVEL_STEP * 9'sd2 -
                   LEVEL_STEP * 9'sd15 + PILOT_OFS);    // RULE_02 RULE_08
        tx_d.lo   = b[3:0];
        tx_d.need = 1'b0;
      end else begin
        tx_d.sym = SYM_W'(9'({5'd0, tx_q.lo}) * LEVEL_STEP * 9'sd2 -
                   LEVEL_STEP * 9'sd15 + PILOT_OFS);    // RULE_02
        tx_d.need = 1'b1;
      end
      // Segment and field counters; 828 data symbols give 414 bytes
      if (tx_q.pos == SEG_SYMS - 10'd1) begin           // RULE_01 RULE_04
        tx_d.pos = 10'd0;
        tx_d.pn  = FS_PN_SEED;
        tx_d.seg = (tx_q.seg == FIELD_SEGS - 9'd1) ?
                   9'd0 : tx_q.seg + 9'd1;              // RULE_06
      end else begin
        tx_d.pos = tx_q.pos + 10'd1;
      end
    end
  end

  // Receive alignment, level code, slicing and de-interleaving
  always_comb begin
    logic [7:0] b;
    rx_d       = rx_q;
    rx_d.byt_v = 1'b0;
    rx_d.der_v = 1'b0;
    rx_wr      = 1'b0;
    rx_in      = 8'h00;
    b          = 8'h00;
    if (rx_sym_valid_i && (rx_q.lock || rx_field_start_i)) begin
      if (rx_field_start_i) begin
        // Field sync realigns everything to the first symbol
        rx_d.lock = 1'b1;
        rx_d.pos  = 10'd1;
        rx_d.seg  = 9'd0;
        rx_d.br   = 6'd0;                               // RULE_09
        rx_d.hi   = 1'b1;
      end else begin
        if (rx_q.pos == SEG_SYMS - 10'd1) begin         // RULE_01
          rx_d.pos = 10'd0;
          rx_d.seg = (rx_q.seg == FIELD_SEGS - 9'd1) ?
                     9'd0 : rx_q.seg + 9'd1;            // RULE_06
        end else begin
          rx_d.pos = rx_q.pos + 10'd1;
        end
        if (rx_q.pos < SYNC_SYMS) begin
          rx_d.hi = 1'b1;                               // RULE_11
        end else if (rx_q.seg == 9'd0) begin
          // Gather the two-level code, adopt it at its last symbol
          if (rx_q.pos >= CODE_POS && rx_q.pos < CODE_POS + 10'd4) begin
            rx_d.code = {rx_q.code[2:0], ~rx_sym_i[SYM_W-1]};
            if (rx_q.pos == CODE_POS + 10'd3) begin
              rx_d.code_q = rx_d.code;                  // RULE_07
              rx_d.lvl16  = (rx_d.code == LEVEL_CODE_16);
            end
          end
        end else if (rx_q.hi) begin
          rx_d.nib = slice;
          rx_d.hi  = 1'b0;
        end else begin
          rx_d.hi = 1'b1;
          rx_in   = {rx_q.nib, slice};                  // RULE_03
          rx_wr   = 1'b1;
          b = (rx_q.br == INTLV_BRANCH - 6'd1) ? rx_in : rx_old; // RULE_05
          rx_d.wp = ring_next(rx_q.wp);
          rx_d.br = (rx_q.br == INTLV_BRANCH - 6'd1) ?
                    6'd0 : rx_q.br + 6'd1;
          rx_d.byt   = b;
          rx_d.byt_v = rx_q.lvl16;                      // RULE_07
        end
      end
    end
    // De-randomizer restarts on every recovered field sync
    if (rx_sym_valid_i && rx_field_start_i) begin
      rx_d.prs = PRS_SEED;                              // RULE_10
    end else if (corr_valid_i) begin
      rx_d.der   = corr_byte_i ^ rx_q.prs[7:0];         // RULE_10
      rx_d.der_v = 1'b1;
      rx_d.prs   = {rx_q.prs[14:0], ^(rx_q.prs & PRS_TAPS)};
    end
  end

  // State registers
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_q      <= '0;
      tx_q.need <= 1'b1;
      tx_q.pn   <= FS_PN_SEED;
      rx_q      <= '0;
      rx_q.hi   <= 1'b1;
      rx_q.prs  <= PRS_SEED;
    end else begin
      tx_q <= tx_d;
      rx_q <= rx_d;
    end
  end

  // Ring memories; no reset, since ring size forbids it
  always_ff @(posedge sys_clk_i) begin
    if (tx_wr) begin
      tx_mem[tx_q.wp] <= tx_in;
    end
    if (rx_wr) begin
      rx_mem[rx_q.wp] <= rx_in;
    end
  end

  // Outputs straight from registers
  assign tx_sym_o         = tx_q.sym;
  assign tx_sym_valid_o   = tx_q.sym_v;
  assign tx_seg_start_o   = tx_q.seg_st;
  assign tx_field_start_o = tx_q.fld_st;
  assign tx_underflow_o   = tx_q.unf;
  assign rx_byte_o        = rx_q.byt;
  assign rx_byte_valid_o  = rx_q.byt_v;
  assign rx_level_code_o  = rx_q.code_q;
  assign rx_levels_ok_o   = rx_q.lvl16;
  assign rx_locked_o      = rx_q.lock;
  assign derand_byte_o    = rx_q.der;
  assign derand_valid_o   = rx_q.der_v;
endmodule

/* File: dv/cable_vsb_symbol_path_properties.sv */
// Port-level temporal checks for the cable symbol path
`timescale 1ns/1ps
module cable_vsb_checker
  import cable_vsb_pkg::*;
(
  // Clock and reset
  input wire logic             sys_clk_i,
  input wire logic             sys_rst_i,
  // Transmit side
  input wire logic             tx_sym_req_i,
  input wire logic [SYM_W-1:0] tx_sym_o,
  input wire logic             tx_sym_valid_o,
  input wire logic             tx_seg_start_o,
  input wire logic             tx_field_start_o,
  // Receive side
  input wire logic             rx_sym_valid_i,
  input wire logic             rx_field_start_i,
  input wire logic             rx_byte_valid_o,
  input wire logic [3:0]       rx_level_code_o,
  input wire logic             rx_levels_ok_o,
  input wire logic             rx_locked_o,
  // De-randomizer
  input wire logic             corr_valid_i,
  input wire logic             derand_valid_o
);
  // Single domain, so one clock and one disable for all
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_SYM_ANSWER: assert property (tx_sym_req_i |=> tx_sym_valid_o)
    else $error("symbol request not answered next cycle");
  AST_SYM_NO_EXTRA: assert property (
    !tx_sym_req_i |=> !tx_sym_valid_o)
    else $error("symbol valid without request");
  AST_SEG_SYNC: assert property (tx_seg_start_o |->
    tx_sym_valid_o && $signed(tx_sym_o) == SYNC_AMP)
    else $error("segment start not sync");
  AST_FIELD_SEG: assert property (
    tx_field_start_o |-> tx_seg_start_o)
    else $error("field start off a segment start");
  AST_SYNC_NEXT: assert property (tx_seg_start_o && tx_sym_req_i |=>
    $signed(tx_sym_o) == -SYNC_AMP) else $error("second sync symbol wrong");
  AST_LEVEL_FLAG: assert property (rx_levels_ok_o ==
    (rx_level_code_o == LEVEL_CODE_16)) else $error("level flag mismatch");
  AST_BYTE_GATED: assert property (
    rx_byte_valid_o |-> rx_levels_ok_o)
    else $error("byte out with wrong level count");
  AST_LOCK_SET: assert property (rx_sym_valid_i && rx_field_start_i
    |=> rx_locked_o) else $error("no lock after field sync");
  AST_LOCK_HOLD: assert property (rx_locked_o |=> rx_locked_o)
    else $error("lock dropped");
  AST_DERAND_ANSWER: assert property (corr_valid_i &&
    !(rx_sym_valid_i && rx_field_start_i) |=> derand_valid_o)
    else $error("corrected byte not answered");
  AST_DERAND_QUIET: assert property (!corr_valid_i ||
    (rx_sym_valid_i && rx_field_start_i) |=> !derand_valid_o)
    else $error("derand valid without byte");
endmodule

bind cable_vsb_symbol_path cable_vsb_checker cable_vsb_checker_i (
  .sys_clk_i, .sys_rst_i, .tx_sym_req_i, .tx_sym_o, .tx_sym_valid_o,
  .tx_seg_start_o, .tx_field_start_o, .rx_sym_valid_i, .rx_field_start_i,
  .rx_byte_valid_o, .rx_level_code_o, .rx_levels_ok_o, .rx_locked_o,
  .corr_valid_i, .derand_valid_o);

/* File: dv/vsb_link_model.sv */
// Modulator and demodulator stand-in on the symbol side
`timescale 1ns/1ps
module vsb_link_model
  import cable_vsb_pkg::*;
(
  // Clock, reset and pacing
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             run_i,
  input  wire logic             slow_i,
  // Transmit symbols from the block
  output logic                  tx_sym_req_o,
  input  wire logic [SYM_W-1:0] tx_sym_i,
  input  wire logic             tx_sym_valid_i,
  input  wire logic             tx_seg_start_i,
  input  wire logic             tx_field_start_i,
  input  wire logic             tx_underflow_i,
  // Receive symbols into the block
  output logic [SYM_W-1:0]      rx_sym_o,
  output logic                  rx_sym_valid_o,
  output logic                  rx_field_start_o
);
  logic signed [SYM_W-1:0] sym_q[$];   // Captured symbols
  logic [1:0]              flg_q[$];   // Segment and field start flags
  int                      uf_cnt = 0; // Underflow pulses seen

  initial begin
    rx_sym_o = 9'h000;
    rx_sym_valid_o = 1'b0;
    rx_field_start_o = 1'b0;
  end
  // Slow mode leaves a gap after each request to stall the FIFO drain
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) tx_sym_req_o <= 1'b0;
    else tx_sym_req_o <= run_i && !(slow_i && tx_sym_req_o);
  end
  // Log every answered symbol
  always @(posedge clk_i) begin
    if (tx_sym_valid_i) begin
      sym_q.push_back(tx_sym_i);
      flg_q.push_back({tx_seg_start_i, tx_field_start_i});
    end
    if (tx_underflow_i) uf_cnt++;
  end
  // One symbol, launched just after an edge
  task automatic send(input int v, input logic fs);
    @(posedge clk_i);
    rx_sym_o <= v[SYM_W-1:0];
    rx_sym_valid_o <= 1'b1;
    rx_field_start_o <= fs;
  endtask
  // Release: invert the line so stale data never looks held
  task automatic quiet();
    @(posedge clk_i);
    rx_sym_o <= ~rx_sym_o;
    rx_sym_valid_o <= 1'b0;
    rx_field_start_o <= 1'b0;
  endtask
  // Field sync with level code, then data up to byte 51 (hi, lo)
  task automatic field(input logic [3:0] code, input int hi, input int lo);
    for (int p = 0; p < 832; p++)
      send((p > 103 && p < 108) ? (code[107-p] ? SYNC_AMP : -SYNC_AMP) :
           ((p % 3) ? -SYNC_AMP : SYNC_AMP), p == 0);
    for (int p = 0; p < 4; p++)
      send((p == 0 || p == 3) ? SYNC_AMP : -SYNC_AMP, 1'b0);
    for (int k = 0; k < 102; k++) send(16 * (k % 16) - 110, 1'b0);
    send(hi, 1'b0);
    send(lo, 1'b0);
    quiet();
  endtask
endmodule

/* File: dv/tb_cable_vsb_symbol_path.sv */
// Self-checking bench for the cable symbol path
`timescale 1ns/1ps
module tb_cable_vsb_symbol_path import cable_vsb_pkg::*;;
  logic             sys_clk_i = 1'b0;
  logic             sys_rst_i = 1'b1;
  logic [7:0]       tx_byte_i = 8'h00;
  logic             tx_valid_i = 1'b0;
  logic             run = 1'b0;
  logic             slow = 1'b0;
  logic [7:0]       corr_byte_i = 8'h00;
  logic             corr_valid_i = 1'b0;
  logic             tx_ready_o, tx_sym_req_i, tx_sym_valid_o;
  logic             tx_seg_start_o, tx_field_start_o, tx_underflow_o;
  logic [SYM_W-1:0] tx_sym_o, rx_sym_i;
  logic             rx_sym_valid_i, rx_field_start_i, rx_byte_valid_o;
  logic [7:0]       rx_byte_o, derand_byte_o;
  logic [3:0]       rx_level_code_o;
  logic             rx_levels_ok_o, rx_locked_o, derand_valid_o;
  int               miscompares = 0;
  int               n_compared = 0;

  always #4 sys_clk_i = ~sys_clk_i;

  cable_vsb_symbol_path cable_vsb_symbol_path_i (.sys_clk_i, .sys_rst_i,
    .tx_byte_i, .tx_valid_i, .tx_ready_o, .tx_sym_req_i, .tx_sym_o,
    .tx_sym_valid_o, .tx_seg_start_o, .tx_field_start_o, .tx_underflow_o,
    .rx_sym_i, .rx_sym_valid_i, .rx_field_start_i, .rx_byte_o,
    .rx_byte_valid_o, .rx_level_code_o, .rx_levels_ok_o, .rx_locked_o,
    .corr_byte_i, .corr_valid_i, .derand_byte_o, .derand_valid_o);
  vsb_link_model vsb_link_model_i (.clk_i(sys_clk_i), .rst_i(sys_rst_i),
    .run_i(run), .slow_i(slow), .tx_sym_req_o(tx_sym_req_i),
    .tx_sym_i(tx_sym_o), .tx_sym_valid_i(tx_sym_valid_o),
    .tx_seg_start_i(tx_seg_start_o), .tx_field_start_i(tx_field_start_o),
    .tx_underflow_i(tx_underflow_o), .rx_sym_o(rx_sym_i),
    .rx_sym_valid_o(rx_sym_valid_i), .rx_field_start_o(rx_field_start_i));

  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bounded wait on the captured symbol count
  task automatic wait_syms(input int n);
    for (int i = 0; vsb_link_model_i.sym_q.size() < n; i++) begin
      if (i > 5000) begin
        miscompares++;
        summarize();
      end
      @(posedge sys_clk_i);
    end
  endtask
  function automatic logic [15:0] sq(input int i);
    return 16'(vsb_link_model_i.sym_q[i]);
  endfunction
  task automatic t_reset();
    check("ready", tx_ready_o, 1'b1);
    check("sym valid", tx_sym_valid_o, 1'b0);
    check("locked", rx_locked_o, 1'b0);
    check("derand valid", derand_valid_o, 1'b0);
  endtask
  // Fill until refused, then frame out while the drain stalls
  task automatic t_tx_frame();
    int n;
    int bad;
    n = 0;
    bad = 0;
    @(posedge sys_clk_i);
    tx_valid_i <= 1'b1;
    tx_byte_i <= 8'hC3;
    for (int i = 0; i < 40; i++) begin
      @(posedge sys_clk_i);
      if (tx_ready_o === 1'b1) begin
        n++;
        tx_byte_i <= 8'hC3 + 8'(n);
      end
    end
    tx_valid_i <= 1'b0;
    check("fill count", 16'(n), 16'(FIFO_DEPTH));
    check("ready full", tx_ready_o, 1'b0);
    run <= 1'b1;
    wait_syms(832);
    slow <= 1'b1;
    wait_syms(942);
    run <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    check("field flags", vsb_link_model_i.flg_q[0], 2'b11);
    check("pos1 flags", vsb_link_model_i.flg_q[1], 2'b00);
    check("seg1 flags", vsb_link_model_i.flg_q[832], 2'b10);
    for (int i = 0; i < 832; i++)
      if (sq(i) !== 16'(SYNC_AMP) && sq(i) !== 16'(-SYNC_AMP)) bad++;
    check("field sync two-level", 16'(bad), 16'h0000);
    for (int i = 104; i < 108; i++)
      check("code sym", sq(i), 16'(40));
    for (int i = 0; i < 4; i++)
      check("sync", sq(832 + i), 16'(i % 3 ? -40 : 40));
    check("hi nibble", sq(836), 16'(16 * 12 - 110));
    check("lo nibble", sq(837), 16'(16 * 3 - 110));
    check("empty byte hi", sq(940), 16'(-110));
    check("empty byte lo", sq(941), 16'(-110));
    check("underflows", vsb_link_model_i.uf_cnt >= 37, 1'b1);
    check("ready drained", tx_ready_o, 1'b1);
  endtask
  // Receive a field; byte 51 leaves the de-interleaver undelayed
  task automatic t_rx(input logic [3:0] code, input int hi, input int lo,
                      input logic [7:0] exp);
    logic seen;
    seen = 1'b0;
    vsb_link_model_i.field(code, hi, lo);
    for (int i = 0; i < 3 && !seen; i++) begin
      #1;
      if (rx_byte_valid_o === 1'b1) begin
        seen = 1'b1;
        check("rx byte", rx_byte_o, exp);
      end
      else @(posedge sys_clk_i);
    end
    check("byte out", seen, code == LEVEL_CODE_16);
    check("level code", rx_level_code_o, code);
    check("levels ok", rx_levels_ok_o, code == LEVEL_CODE_16);
    check("locked", rx_locked_o, 1'b1);
  endtask
  // One corrected byte; with fs a field start lands on the same edge
  task automatic corr(input logic [7:0] b, input logic fs,
                      inout logic [15:0] prs);
    if (fs) vsb_link_model_i.send(SYNC_AMP, 1'b1);
    else @(posedge sys_clk_i);
    corr_byte_i <= b;
    corr_valid_i <= 1'b1;
    if (fs) vsb_link_model_i.quiet();
    else @(posedge sys_clk_i);
    corr_valid_i <= 1'b0;
    #1;
    check("derand valid", derand_valid_o, !fs);
    if (fs) prs = PRS_SEED;
    else begin
      check("derand byte", derand_byte_o, b ^ prs[7:0]);
      prs = {prs[14:0], ^(prs & PRS_TAPS)};
    end
  endtask
  task automatic t_derand();
    logic [15:0] prs;
    prs = PRS_SEED;
    for (int i = 0; i < 4; i++) corr(8'h5A + 8'(i * 8'h25), 1'b0, prs);
    corr(8'h00, 1'b1, prs);
    corr(8'hE7, 1'b0, prs);
  endtask

  initial begin
    repeat (3) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge sys_clk_i);
    t_reset();
    t_tx_frame();
    t_rx(4'hF, 16 * 10 - 110 + 7, 16 * 5 - 110 - 8, 8'hA5);
    t_rx(4'hF, -200, 200, 8'h0F);
    t_rx(4'h6, 16 * 10 - 110, 16 * 5 - 110, 8'hA5);
    t_derand();
    summarize();
  end
endmodule
